// [hw/bft_pkg.sv]
// Package of constants and types for the bit-field test and branch unit
package bft_pkg;
   localparam int DATA_W = 16;
   localparam int PC_W = 16;
   localparam int DISP_W = 7;
   localparam int SHORT_W = 6;
   localparam int REGF_W = 5;
   localparam int CNT_W = 5;
   localparam int RADDR_W = 4;
   // Status word field positions
   localparam int SW_CARRY_BIT = 0;
   localparam int SW_LIMIT_BIT = 6;
   localparam logic [DATA_W-1:0] SW_RESET = 16'h0000;
   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   // Peripheral I/O space holds the top 64 addresses
   localparam logic [DATA_W-1:0] IO_BASE = 16'hffc0;
   // Register word offsets
   localparam logic [RADDR_W-1:0] REG_STATUS_WORD = 4'h0;
   localparam logic [RADDR_W-1:0] REG_PC = 4'h1;
   localparam logic [RADDR_W-1:0] REG_WAIT = 4'h2;
   localparam logic [RADDR_W-1:0] REG_EXEC = 4'h3;
   localparam logic [3:0] WAIT_RESET = 4'h0;
   // Exec status bit positions
   localparam int EX_BUSY_BIT = 0;
   localparam int EX_CARRY_BIT = 1;
   localparam int EX_TAKEN_BIT = 2;
   localparam int EX_BADMASK_BIT = 3;
   // Cycle and word costs
   localparam logic [CNT_W-1:0] CYC_TEST_SHORT = 5'h04;
   localparam logic [CNT_W-1:0] CYC_TEST_LONG = 5'h06;
   localparam logic [CNT_W-1:0] CYC_JUMP = 5'h06;
   localparam logic [CNT_W-1:0] CYC_BRZ_SHORT_TAKEN = 5'h0a;
   localparam logic [CNT_W-1:0] CYC_BRZ_SHORT_NOT = 5'h08;
   localparam logic [CNT_W-1:0] CYC_BRZ_LONG_TAKEN = 5'h0c;
   localparam logic [CNT_W-1:0] CYC_BRZ_LONG_NOT = 5'h0a;
   localparam logic [1:0] WORDS_ONE = 2'h1;
   localparam logic [1:0] WORDS_TWO = 2'h2;
   localparam logic [1:0] WORDS_THREE = 2'h3;
   typedef enum logic [1:0] {
      TEST_BITS_FOR_ONES_OP, TEST_BITS_FOR_ZEROS_OP, RELATIVE_JUMP_OP, BRANCH_IF_ZEROS_OP
   } bft_op_t;
   typedef enum logic [2:0] {
      FORM_REG, FORM_IDX_R2, FORM_IDX_SP, FORM_SHORT_DATA, FORM_SHORT_IO, FORM_LONG
   } bft_form_t;
endpackage : bft_pkg

// [hw/bft_tester.sv]
// Masked all-ones or all-zeros operand test
`timescale 1ns/1ps
module bft_tester #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] i_mask,
   input wire logic [WIDTH-1:0] i_value,
   input wire logic i_zeros_mode,
   output logic o_all_match
);
   logic [WIDTH-1:0] bit_ok;
   // Each selected bit must equal the wanted level; unselected bits pass
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      assign bit_ok[g] = ~i_mask[g] | (i_value[g] ^ i_zeros_mode);
   end
   // An empty mask yields a match
   assign o_all_match = &bit_ok;
endmodule : bft_tester

// [hw/bft_rel_target.sv]
// PC-relative branch target from a 7-bit signed displacement
`timescale 1ns/1ps
module bft_rel_target #(
   parameter int PCW = 16,
   parameter int DW = 7
) (
   input wire logic [PCW-1:0] i_next_pc,
   input wire logic [DW-1:0] i_disp,
   output logic [PCW-1:0] o_target
);
   logic [PCW-1:0] disp_ext;
   // Sign extension then wrap-around add
   assign disp_ext = {{(PCW-DW){i_disp[DW-1]}}, i_disp};
   assign o_target = i_next_pc + disp_ext;
endmodule : bft_rel_target

// [hw/bft_exec.sv]
// Execution unit for bit-field tests, relative jump and branch-if-zeros
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module bft_exec (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire bft_pkg::bft_op_t i_op,
   input wire bft_pkg::bft_form_t i_form,
   input wire logic [bft_pkg::DATA_W-1:0] i_mask,
   input wire logic [bft_pkg::REGF_W-1:0] i_reg_field,
   input wire logic [bft_pkg::SHORT_W-1:0] i_short_addr,
   input wire logic [bft_pkg::DATA_W-1:0] i_ea,
   input wire logic [bft_pkg::DISP_W-1:0] i_disp,
   input wire logic i_src_limited,
   input wire logic [bft_pkg::DATA_W-1:0] i_acc_rdata,
   output logic o_acc_rd,
   output logic o_acc_wr,
   output logic o_acc_reg,
   output logic o_acc_io,
   output logic [bft_pkg::DATA_W-1:0] o_acc_addr,
   output logic [bft_pkg::DATA_W-1:0] o_acc_wdata,
   output logic o_busy,
   output logic o_done,
   output logic o_branch_taken,
   output logic [1:0] o_words,
   output logic [bft_pkg::PC_W-1:0] o_pc,
   output logic [bft_pkg::DATA_W-1:0] o_status_word,
   input wire logic [bft_pkg::RADDR_W-1:0] i_reg_addr,
   input wire logic [bft_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [bft_pkg::DATA_W-1:0] o_reg_rdata
);
   import bft_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_END} bft_state_t;

   bft_state_t state_q;
   bft_op_t op_q;
   logic [DATA_W-1:0] mask_q;
   logic [DISP_W-1:0] disp_q;
   logic [CNT_W-1:0] step_q;
   logic [CNT_W-1:0] cost_q;
   logic long_q;
   logic [DATA_W-1:0] opnd_q;
   logic carry_q;
   logic lim_q;
   logic taken_q;
   logic bad_mask_q;
   logic [DATA_W-1:0] sw_q;
   logic [PC_W-1:0] pc_q;
   logic [3:0] wait_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] acc_addr_q;
   logic acc_reg_q;
   logic acc_io_q;
   logic [1:0] words_q;
   logic all_match;
   logic [PC_W-1:0] target;
   logic is_test;
   logic uses_opnd;
   logic run_end;

   // Word count of each opcode and addressing form
   function automatic logic [1:0] words_of(bft_op_t op, bft_form_t form);
      if (op == RELATIVE_JUMP_OP) begin
         return WORDS_ONE;
      end
      return (form == FORM_LONG) ? WORDS_THREE : WORDS_TWO;
   endfunction : words_of

   // Form class that costs the longer timing
   function automatic logic is_long_form(bft_form_t form);
      return (form == FORM_IDX_R2) || (form == FORM_IDX_SP) || (form == FORM_LONG);
   endfunction : is_long_form

   assign is_test = (op_q == TEST_BITS_FOR_ONES_OP) || (op_q == TEST_BITS_FOR_ZEROS_OP);
   assign uses_opnd = (op_q != RELATIVE_JUMP_OP);
   assign run_end = (state_q == ST_RUN) && (step_q == cost_q - 5'h01);

   bft_tester #(
      .WIDTH(DATA_W)
   ) u_tester (
      .i_mask(mask_q),
      .i_value(i_acc_rdata),
      .i_zeros_mode(op_q != TEST_BITS_FOR_ONES_OP),
      .o_all_match(all_match)
   );

   bft_rel_target #(
      .PCW(PC_W),
      .DW(DISP_W)
   ) u_target (
      .i_next_pc(pc_q),
      .i_disp(disp_q),
      .o_target(target)
   );

   // Sequencer: idle, run the costed cycles, commit
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         step_q <= 5'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               step_q <= 5'h00;
               if (i_start) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               step_q <= step_q + 5'h01;
               if (run_end) begin
                  state_q <= ST_END;
               end
            end
            ST_END: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Instruction capture and operand address decode
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         op_q <= TEST_BITS_FOR_ONES_OP;
         mask_q <= '0;
         disp_q <= '0;
         long_q <= 1'b0;
         acc_addr_q <= '0;
         acc_reg_q <= 1'b0;
         acc_io_q <= 1'b0;
         words_q <= WORDS_ONE;
      end else if (state_q == ST_IDLE && i_start) begin
         op_q <= i_op;
         // Byte mask arrives already zero in its unused half
         mask_q <= i_mask;
         disp_q <= i_disp;
         long_q <= is_long_form(i_form);
         words_q <= words_of(i_op, i_form);
         acc_reg_q <= (i_form == FORM_REG);
         acc_io_q <= (i_form == FORM_SHORT_IO);
         case (i_form)
            FORM_REG: acc_addr_q <= {{(DATA_W-REGF_W){1'b0}}, i_reg_field};
            FORM_SHORT_DATA: acc_addr_q <= {{(DATA_W-SHORT_W){1'b0}}, i_short_addr};
            FORM_SHORT_IO: acc_addr_q <= IO_BASE | {{(DATA_W-SHORT_W){1'b0}}, i_short_addr};
            default: acc_addr_q <= i_ea;
         endcase
      end
   end

   // Cost: fixed for tests, CYC_JUMP plus wait states for jump, decided by the test for branch-if-zeros
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cost_q <= CYC_TEST_SHORT;
      end else if (state_q == ST_IDLE && i_start) begin
         case (i_op)
            RELATIVE_JUMP_OP: cost_q <= CYC_JUMP + {1'b0, wait_q};
            BRANCH_IF_ZEROS_OP: cost_q <= is_long_form(i_form) ? CYC_BRZ_LONG_TAKEN
                                                             : CYC_BRZ_SHORT_TAKEN;
            default: cost_q <= is_long_form(i_form) ? CYC_TEST_LONG : CYC_TEST_SHORT;
         endcase
      end else if (state_q == ST_RUN && step_q == 5'h01 && op_q == BRANCH_IF_ZEROS_OP
                   && !all_match) begin
         cost_q <= long_q ? CYC_BRZ_LONG_NOT : CYC_BRZ_SHORT_NOT;
      end
   end

   // Operand read in step 0, data and test result in step 1
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         opnd_q <= '0;
         carry_q <= 1'b0;
      end else if (state_q == ST_RUN && step_q == 5'h01 && uses_opnd) begin
         opnd_q <= i_acc_rdata;
         carry_q <= all_match;
      end
   end

   // Saturation seen while the operand source moves
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lim_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         lim_q <= 1'b0;
      end else if (state_q == ST_RUN && uses_opnd && i_src_limited) begin
         lim_q <= 1'b1;
      end
   end

   // Status word: commit at the end cycle wins over a software write
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sw_q <= SW_RESET;
      end else if (state_q == ST_END && uses_opnd) begin
         sw_q[SW_CARRY_BIT] <= carry_q;
         if (lim_q) begin
            sw_q[SW_LIMIT_BIT] <= 1'b1;
         end
      end else if (i_reg_wr && i_reg_addr == REG_STATUS_WORD) begin
         sw_q <= i_reg_wdata;
      end
   end

   // Program counter points past the instruction, then branches
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pc_q <= PC_RESET;
         taken_q <= 1'b0;
      end else if (state_q == ST_IDLE && i_start) begin
         pc_q <= pc_q + {{(PC_W-2){1'b0}}, words_of(i_op, i_form)};
         taken_q <= 1'b0;
      end else if (state_q == ST_END) begin
         if (op_q == RELATIVE_JUMP_OP || (op_q == BRANCH_IF_ZEROS_OP && carry_q)) begin
            pc_q <= target;
            taken_q <= 1'b1;
         end
      end else if (state_q == ST_IDLE && i_reg_wr && i_reg_addr == REG_PC) begin
         pc_q <= i_reg_wdata;
      end
   end

   // Software configuration and the sticky bad-mask indication
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_q <= WAIT_RESET;
         bad_mask_q <= 1'b0;
      end else begin
         if (i_reg_wr && i_reg_addr == REG_WAIT) begin
            wait_q <= i_reg_wdata[3:0];
         end
         if (state_q == ST_IDLE && i_start && i_op == BRANCH_IF_ZEROS_OP
             && i_mask[15:8] != 8'h00 && i_mask[7:0] != 8'h00) begin
            bad_mask_q <= 1'b1;
         end else if (i_reg_wr && i_reg_addr == REG_EXEC && i_reg_wdata[EX_BADMASK_BIT]) begin
            bad_mask_q <= 1'b0;
         end
      end
   end

   // Register read data, valid the cycle after the strobe
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_q <= '0;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            REG_STATUS_WORD: rdata_q <= sw_q;
            REG_PC: rdata_q <= pc_q;
            REG_WAIT: rdata_q <= {12'h000, wait_q};
            REG_EXEC: rdata_q <= {12'h000, bad_mask_q, taken_q, carry_q, state_q != ST_IDLE};
            default: rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   // Access strobes: read in step 0, unchanged write-back in step 2
   assign o_acc_rd = (state_q == ST_RUN) && (step_q == 5'h00) && uses_opnd;
   assign o_acc_wr = (state_q == ST_RUN) && (step_q == 5'h02) && is_test;
   assign o_acc_wdata = opnd_q;
   assign o_acc_addr = acc_addr_q;
   assign o_acc_reg = acc_reg_q;
   assign o_acc_io = acc_io_q;
   assign o_busy = (state_q != ST_IDLE);
   assign o_done = (state_q == ST_END);
   assign o_branch_taken = taken_q;
   assign o_words = words_q;
   assign o_pc = pc_q;
   assign o_status_word = sw_q;
   assign o_reg_rdata = rdata_q;

   // Checks on timing, flags and branch
   property p_cost(bft_op_t op, logic [CNT_W-1:0] n);
      @(posedge i_core_clk) disable iff (!i_reset_n)
         (state_q == ST_IDLE && i_start && i_op == op && i_form == FORM_REG)
         |-> ##(1) (state_q == ST_RUN) [*1] ##0 (cost_q == n);
   endproperty
   test_short_cost_a: assert property (p_cost(TEST_BITS_FOR_ONES_OP, CYC_TEST_SHORT))
      else $error("short test cost wrong");
   jump_cost_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_IDLE && i_start && i_op == RELATIVE_JUMP_OP)
      |=> cost_q == CYC_JUMP + {1'b0, $past(wait_q)} && words_q == WORDS_ONE)
      else $error("jump cost or words wrong");
   long_words_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_IDLE && i_start && i_op != RELATIVE_JUMP_OP && i_form == FORM_LONG)
      |=> words_q == WORDS_THREE)
      else $error("long form words wrong");
   two_access_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_IDLE && i_start && (i_op == TEST_BITS_FOR_ONES_OP
       || i_op == TEST_BITS_FOR_ZEROS_OP))
      |=> o_acc_rd ##1 !o_acc_rd ##1 (o_acc_wr && o_acc_wdata == $past(i_acc_rdata)))
      else $error("test access pair wrong");
   carry_commit_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_END && uses_opnd) |=> sw_q[SW_CARRY_BIT] == $past(carry_q))
      else $error("carry not committed");
   jump_flags_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_END && op_q == RELATIVE_JUMP_OP) |=> sw_q == $past(sw_q))
      else $error("jump changed status word");
   other_flags_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_END && uses_opnd)
      |=> (sw_q & 16'hffbe) == ($past(sw_q) & 16'hffbe))
      else $error("untouched flags changed");
   empty_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_RUN && step_q == 5'h01 && uses_opnd && mask_q == 16'h0000)
      |=> carry_q)
      else $error("empty mask did not set carry");
   branch_target_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_END && op_q == BRANCH_IF_ZEROS_OP && carry_q)
      |=> pc_q == $past(pc_q) + {{9{$past(disp_q[6])}}, $past(disp_q)})
      else $error("branch target wrong");
   limit_set_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state_q == ST_RUN && uses_opnd && i_src_limited)
      |-> ##[1:13] (state_q == ST_IDLE && sw_q[SW_LIMIT_BIT]))
      else $error("limit flag not set");
   cov_jump_c: cover property (@(posedge i_core_clk) state_q == ST_END
      && op_q == RELATIVE_JUMP_OP);
   cov_brz_taken_c: cover property (@(posedge i_core_clk) state_q == ST_END
      && op_q == BRANCH_IF_ZEROS_OP && carry_q);
   cov_brz_fall_c: cover property (@(posedge i_core_clk) state_q == ST_END
      && op_q == BRANCH_IF_ZEROS_OP && !carry_q);
   cov_test_c: cover property (@(posedge i_core_clk) o_acc_wr);
endmodule : bft_exec

// [test/test_bit_field_test_branch_exec.sv]
// Self-checking bench for the bit-field test and relative branch execution unit
`timescale 1ns/1ps
module test_bit_field_test_branch_exec;
   import bft_pkg::*;
   logic i_core_clk, i_reset_n, i_start, i_src_limited, i_reg_wr, i_reg_rd;
   bft_op_t i_op;
   bft_form_t i_form;
   logic [DATA_W-1:0] i_mask, i_ea, i_acc_rdata, i_reg_wdata, opnd;
   logic [REGF_W-1:0] i_reg_field;
   logic [SHORT_W-1:0] i_short_addr;
   logic [DISP_W-1:0] i_disp;
   logic [RADDR_W-1:0] i_reg_addr;
   logic o_acc_rd, o_acc_wr, o_acc_reg, o_acc_io, o_busy, o_done, o_branch_taken;
   logic [1:0] o_words;
   logic [DATA_W-1:0] o_acc_addr, o_acc_wdata, o_status_word, o_reg_rdata;
   logic [PC_W-1:0] o_pc;
   logic [31:0] lfsr = 32'h0395b2a6;
   logic [DATA_W-1:0] sw_m;
   logic [PC_W-1:0] pc_m;
   int wait_m = 0;
   int num_errors = 0;
   int n_checks = 0;
   // Arbitrary code standing for the hardware stack register in the register field
   localparam logic [REGF_W-1:0] STACK_REG_CODE = 5'h1f;
   // Model of the exec status bits: bad mask, taken, last carry, busy
   logic [3:0] exec_m = 4'h0;

   bft_exec bft_exec_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_start(i_start),
      .i_op(i_op), .i_form(i_form), .i_mask(i_mask), .i_reg_field(i_reg_field),
      .i_short_addr(i_short_addr), .i_ea(i_ea), .i_disp(i_disp),
      .i_src_limited(i_src_limited), .i_acc_rdata(i_acc_rdata), .o_acc_rd(o_acc_rd),
      .o_acc_wr(o_acc_wr), .o_acc_reg(o_acc_reg), .o_acc_io(o_acc_io),
      .o_acc_addr(o_acc_addr), .o_acc_wdata(o_acc_wdata), .o_busy(o_busy), .o_done(o_done),
      .o_branch_taken(o_branch_taken), .o_words(o_words), .o_pc(o_pc),
      .o_status_word(o_status_word), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

   // Core clock, 10 ns period
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // Operand store answers a read in the next cycle; otherwise shows the inverse
   always @(posedge i_core_clk) i_acc_rdata <= o_acc_rd ? opnd : ~opnd;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic rnd(output logic [15:0] r);
      repeat (16) lfsr = lfsr_next(lfsr);
      r = lfsr[15:0];
   endtask : rnd

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic give_verdict;
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic reg_wr(input logic [RADDR_W-1:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_core_clk);
      i_reg_wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [RADDR_W-1:0] a, input logic [15:0] exp);
      @(posedge i_core_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_core_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_core_clk);
      chk("register read", exp, o_reg_rdata);
   endtask : reg_rd

   // One operation: timing, operand accesses, then flags and PC against the model
   task automatic run_op(input bft_op_t op, input bft_form_t f, input logic [15:0] m,
                         input logic [15:0] v, input logic lim, input logic [6:0] d);
      logic [15:0] ea, t, adr;
      logic [1:0] words;
      logic carry, take, longf;
      int cost, n, nrd, nwr;
      rnd(ea);
      rnd(t);
      if (t[4:0] == STACK_REG_CODE) t[4:0] = 5'h00;
      longf = (f == FORM_IDX_R2) || (f == FORM_IDX_SP) || (f == FORM_LONG);
      words = (op == RELATIVE_JUMP_OP) ? 2'h1 : (f == FORM_LONG) ? 2'h3 : 2'h2;
      carry = (op == TEST_BITS_FOR_ONES_OP) ? ((v & m) == m) : ((v & m) == 16'h0000);
      take = (op == RELATIVE_JUMP_OP) || (op == BRANCH_IF_ZEROS_OP && carry);
      cost = longf ? 6 : 4;
      if (op == RELATIVE_JUMP_OP) cost = 6 + wait_m;
      if (op == BRANCH_IF_ZEROS_OP) cost = (longf ? 12 : 10) - (carry ? 0 : 2);
      adr = ea;
      if (f == FORM_REG) adr = {11'h000, t[4:0]};
      if (f == FORM_SHORT_DATA) adr = {10'h000, t[10:5]};
      if (f == FORM_SHORT_IO) adr = IO_BASE | {10'h000, t[10:5]};
      @(posedge i_core_clk);
      i_start <= 1'b1;
      i_op <= op;
      i_form <= f;
      i_mask <= m;
      i_ea <= ea;
      i_reg_field <= t[4:0];
      i_short_addr <= t[10:5];
      i_disp <= d;
      i_src_limited <= lim;
      opnd = v;
      @(posedge i_core_clk);
      i_start <= 1'b0;
      n = 0;
      nrd = 0;
      nwr = 0;
      do begin
         @(negedge i_core_clk);
         n++;
         chk("busy", 16'h0001, {15'h0000, o_busy});
         if (o_acc_rd === 1'b1) begin
            nrd++;
            chk("operand address", adr, o_acc_addr);
            chk("register operand", {15'h0000, f == FORM_REG}, {15'h0000, o_acc_reg});
            chk("io operand", {15'h0000, f == FORM_SHORT_IO}, {15'h0000, o_acc_io});
         end
         if (o_acc_wr === 1'b1) begin
            nwr++;
            chk("write-back data", v, o_acc_wdata);
         end
      end while (o_done !== 1'b1 && n < 40);
      chk("cycles to done", 16'(cost + 1), 16'(n));
      chk("operand reads", (op == RELATIVE_JUMP_OP) ? 16'h0 : 16'h1, 16'(nrd));
      chk("operand writes", (op < RELATIVE_JUMP_OP) ? 16'h1 : 16'h0, 16'(nwr));
      pc_m = pc_m + {14'h0000, words};
      if (take) pc_m = pc_m + {{9{d[6]}}, d};
      if (op != RELATIVE_JUMP_OP) begin
         sw_m[SW_CARRY_BIT] = carry;
         if (lim) sw_m[SW_LIMIT_BIT] = 1'b1;
         exec_m[EX_CARRY_BIT] = carry;
      end
      exec_m[EX_TAKEN_BIT] = take;
      if (op == BRANCH_IF_ZEROS_OP && m[15:8] != 8'h00 && m[7:0] != 8'h00) begin
         exec_m[EX_BADMASK_BIT] = 1'b1;
      end
      @(negedge i_core_clk);
      chk("idle", 16'h0000, {15'h0000, o_busy});
      chk("status word", sw_m, o_status_word);
      chk("program counter", pc_m, o_pc);
      chk("branch taken", {15'h0000, take}, {15'h0000, o_branch_taken});
      chk("word count", {14'h0000, words}, {14'h0000, o_words});
      reg_rd(REG_EXEC, {12'h000, exec_m});
   endtask : run_op

   // Hang guard, far beyond the expected run length
   initial begin
      repeat (30000) @(posedge i_core_clk);
      num_errors++;
      give_verdict();
   end

   // Main sequence
   initial begin
      logic [15:0] s, m, v, x;
      i_reset_n = 1'b0;
      i_start = 1'b0;
      i_op = TEST_BITS_FOR_ONES_OP;
      i_form = FORM_REG;
      i_mask = 16'h0000;
      i_ea = 16'h0000;
      i_reg_field = 5'h00;
      i_short_addr = 6'h00;
      i_disp = 7'h00;
      i_src_limited = 1'b0;
      i_reg_addr = 4'h0;
      i_reg_wdata = 16'h0000;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      opnd = 16'h0000;
      repeat (10) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      sw_m = SW_RESET;
      pc_m = PC_RESET;
      reg_rd(REG_STATUS_WORD, SW_RESET);
      reg_rd(REG_PC, PC_RESET);
      reg_rd(REG_WAIT, {12'h000, WAIT_RESET});
      reg_rd(REG_EXEC, 16'h0000);
      reg_rd(4'hf, 16'h0000);
      // All-zero masks on every operation, most negative displacement
      for (int k = 0; k < 4; k++) begin
         run_op(bft_op_t'(k), FORM_SHORT_IO, 16'h0000, 16'h5a5a, 1'b0, 7'h40);
      end
      // A byte mask with both halves set is flagged; writing one to the flag clears it
      run_op(BRANCH_IF_ZEROS_OP, FORM_REG, 16'h0101, 16'h0000, 1'b0, 7'h05);
      reg_wr(REG_EXEC, 16'h0008);
      exec_m[EX_BADMASK_BIT] = 1'b0;
      reg_rd(REG_EXEC, {12'h000, exec_m});
      // Every operation in every addressing form, random flags, masks and operands
      for (int it = 0; it < 3; it++) begin
         for (int o = 0; o < 4; o++) begin
            for (int f = 0; f < 6; f++) begin
               rnd(s);
               reg_wr(REG_STATUS_WORD, s);
               sw_m = s;
               rnd(m);
               rnd(v);
               rnd(x);
               if (o == 3) m = x[0] ? {m[7:0], 8'h00} : {8'h00, m[7:0]};
               if (x[1]) v = (o == 0) ? (v | m) : (v & ~m);
               run_op(bft_op_t'(o), bft_form_t'(f), m, v, x[2], x[9:3]);
            end
         end
      end
      // Program counter write, then a jump with program-memory wait states
      rnd(s);
      reg_wr(REG_PC, s);
      pc_m = s;
      reg_rd(REG_PC, pc_m);
      reg_wr(REG_WAIT, 16'h0003);
      wait_m = 3;
      reg_rd(REG_WAIT, 16'h0003);
      // This last jump is issued singly, with the wait register at 3 and the limit input set
      run_op(RELATIVE_JUMP_OP, FORM_REG, 16'h0000, 16'h0000, 1'b1, 7'h3f);
      give_verdict();
   end
endmodule : test_bit_field_test_branch_exec
